//--- verilog/afi_pkg.sv
// Shared constants and types for the axis fault interlock
package afi_pkg;

  // ==========================================================
  // Axes and widths
  localparam int AFI_NAX = 3;
  localparam int AFI_AX_AZ = 0;
  localparam int AFI_AX_EL = 1;
  localparam int AFI_AX_POL = 2;
  localparam int AFI_IW = 12;
  localparam int AFI_PW = 16;
  localparam int AFI_FW = 13;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] AFI_OFS_CTRL = 8'h00;
  localparam logic [7:0] AFI_OFS_AZ_ILIM = 8'h04;
  localparam logic [7:0] AFI_OFS_EL_ILIM = 8'h08;
  localparam logic [7:0] AFI_OFS_POL_TGT = 8'h0C;
  localparam logic [7:0] AFI_OFS_LIM_STAT = 8'h10;
  localparam logic [7:0] AFI_OFS_FAULT = 8'h14;
  localparam logic [7:0] AFI_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] AFI_OFS_IRQ_MASK = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int AFI_CTRL_MRST = 0;
  localparam int AFI_CTRL_CIRC = 1;
  localparam int AFI_CTRL_SLEN = 2;
  localparam int AFI_F_JAM = 0;
  localparam int AFI_F_RUN = 3;
  localparam int AFI_F_DRV = 6;
  localparam int AFI_F_XAX = 9;
  localparam int AFI_F_ESTOP = 12;
  localparam int AFI_L_HWF = 0;
  localparam int AFI_L_HWR = 1;
  localparam int AFI_L_SWF = 2;
  localparam int AFI_L_SWR = 3;
  localparam int AFI_L_STRIDE = 4;

  // ==========================================================
  // Reset values
  localparam logic [2:0] AFI_CTRL_RST = 3'h4;
  localparam logic [11:0] AFI_ILIM_RST = 12'hFFF;
  localparam logic [15:0] AFI_POLT_RST = 16'h0000;
  localparam logic [12:0] AFI_MASK_RST = 13'h0000;

  // ==========================================================
  // Timing
  localparam int AFI_CLK_MHZ = 250;
  localparam int AFI_JAM_TIME_US = 1000;
  localparam int AFI_JAM_CYC = AFI_JAM_TIME_US * AFI_CLK_MHZ;
  localparam int AFI_RUN_TIME_NS = 400;
  localparam int AFI_RUN_CYC = (AFI_RUN_TIME_NS * AFI_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Recall sequencer states
  typedef enum logic [1:0] {
    AFI_RC_IDLE = 2'b01,
    AFI_RC_SEEK = 2'b10
  } afi_rc_state_t;

endpackage

//--- verilog/afi_axis_mon.sv
// Per-axis jam, runaway and drive fault latches
`timescale 1ns/1ns
module afi_axis_mon
  import afi_pkg::*;
#(
  parameter int JAM_CYC = AFI_JAM_CYC,
  parameter int RUN_CYC = AFI_RUN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Observed axis
  input wire logic cmd,
  input wire logic moving,
  input wire logic over_cur,
  input wire logic clr,
  // Latched faults
  output logic jam_r,
  output logic run_r,
  output logic drv_r
);

  localparam logic [23:0] JAM_LAST = 24'(JAM_CYC - 1);
  localparam logic [23:0] RUN_LAST = 24'(RUN_CYC - 1);

  logic [23:0] jam_cnt_r;
  logic [23:0] run_cnt_r;
  logic [23:0] jam_cnt_nxt;
  logic [23:0] run_cnt_nxt;
  logic jam_nxt;
  logic run_nxt;
  logic drv_nxt;

  // ==========================================================
  // Fault detection
  wire jam_cond = cmd & ~moving;
  wire run_cond = ~cmd & moving;
  wire jam_hit = jam_cond & (jam_cnt_r == JAM_LAST);
  wire run_hit = run_cond & (run_cnt_r == RUN_LAST);

  // Counters restart on any break so only a sustained condition latches
  assign jam_cnt_nxt = (!jam_cond || clr) ? 24'h000000 : (jam_hit ? jam_cnt_r : jam_cnt_r + 24'h000001);
  assign run_cnt_nxt = (!run_cond || clr) ? 24'h000000 : (run_hit ? run_cnt_r : run_cnt_r + 24'h000001);
  // Maintenance clear dominates a same-cycle detection
  assign jam_nxt = clr ? 1'b0 : (jam_r | jam_hit);
  assign run_nxt = clr ? 1'b0 : (run_r | run_hit);
  assign drv_nxt = clr ? 1'b0 : (drv_r | over_cur);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      jam_cnt_r <= 24'h000000;
      run_cnt_r <= 24'h000000;
      jam_r <= 1'b0;
      run_r <= 1'b0;
      drv_r <= 1'b0;
    end else if (ce) begin
      jam_cnt_r <= jam_cnt_nxt;
      run_cnt_r <= run_cnt_nxt;
      jam_r <= jam_nxt;
      run_r <= run_nxt;
      drv_r <= drv_nxt;
    end
  end

  // ==========================================================
  // Checks
  jam_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && jam_cond && jam_cnt_r == JAM_LAST && !clr) |=> jam_r)
    else $error("jam not latched after full window");
  run_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && run_cond && run_cnt_r == RUN_LAST && !clr) |=> run_r)
    else $error("runaway not latched after full window");
  drive_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && over_cur && !clr) |=> drv_r ##1 (drv_r || $past(clr) || !$past(ce)))
    else $error("drive fault not latched or lost");
  fault_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && clr) |=> (!jam_r && !run_r && !drv_r))
    else $error("maintenance clear left a fault set");

endmodule

//--- verilog/afi_interlock.sv
// Axis motion interlock and fault supervisor, top level
//
// Contract
// - Azimuth limit switch blocks that direction only; opposite direction stays allowed.
// - Elevation limit switch blocks that direction only; opposite direction stays allowed.
// - Hardware and software limits are reported as separate status flags.
// - Commanded motion without sensed movement latches a jam fault and blocks motion.
// - Sensed movement without command latches a runaway fault and blocks motion.
// - Azimuth or elevation current above its limit latches a drive fault.
// - Any jam or runaway fault blocks all axes until maintenance reset.
// - Axes blocked by another axis's fault show a cross-axis flag.
// - Emergency stop alarm follows the open stop input.
// - Recall drives the polarization axis to its stored target.
// - Circular feed selection suppresses automatic polarization motion.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
module afi_interlock
  import afi_pkg::*;
#(
  parameter int JAM_CYC = AFI_JAM_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Motion requests
  input wire logic [2:0] cmd_fwd,
  input wire logic [2:0] cmd_rev,
  input wire logic recall_go,
  // Sensors
  input wire logic [2:0] hw_lim_fwd,
  input wire logic [2:0] hw_lim_rev,
  input wire logic [2:0] sw_lim_fwd,
  input wire logic [2:0] sw_lim_rev,
  input wire logic [2:0] moving,
  input wire logic [11:0] az_cur,
  input wire logic [11:0] el_cur,
  input wire logic [15:0] pol_pos,
  input wire logic estop_closed,
  // Drive and alarm outputs
  output logic [2:0] drv_fwd,
  output logic [2:0] drv_rev,
  output logic estop_alarm,
  output logic recall_busy,
  output logic irq
);

  // ==========================================================
  // State
  logic [2:0] ctrl_r;
  logic [11:0] az_ilim_r;
  logic [11:0] el_ilim_r;
  logic [15:0] pol_tgt_r;
  logic [12:0] irq_stat_r;
  logic [12:0] irq_mask_r;
  logic [12:0] fault_prev_r;
  logic [31:0] rdata_r;
  logic [2:0] drv_fwd_r;
  logic [2:0] drv_rev_r;
  logic estop_alarm_r;
  logic irq_r;
  afi_rc_state_t rc_state_r;
  afi_rc_state_t rc_state_nxt;

  logic [2:0] jam;
  logic [2:0] run;
  logic [2:0] dflt;
  logic [2:0] xax;
  logic [2:0] blk;
  logic [2:0] lim_fwd;
  logic [2:0] lim_rev;
  logic [2:0] en_fwd;
  logic [2:0] en_rev;
  logic [2:0] req_fwd;
  logic [2:0] req_rev;
  logic [2:0] over_cur;
  logic [2:0] drv_fwd_nxt;
  logic [2:0] drv_rev_nxt;
  logic [11:0] lim_stat;
  logic [12:0] fault_vec;
  logic [12:0] irq_stat_nxt;
  logic [31:0] rd_val;

  // ==========================================================
  // Register decode
  wire wr_ctrl = reg_wr & (reg_addr == AFI_OFS_CTRL);
  wire wr_az_ilim = reg_wr & (reg_addr == AFI_OFS_AZ_ILIM);
  wire wr_el_ilim = reg_wr & (reg_addr == AFI_OFS_EL_ILIM);
  wire wr_pol_tgt = reg_wr & (reg_addr == AFI_OFS_POL_TGT);
  wire wr_mask = reg_wr & (reg_addr == AFI_OFS_IRQ_MASK);
  wire rd_irq = reg_rd & (reg_addr == AFI_OFS_IRQ_STAT);
  wire rd_fault = reg_rd & (reg_addr == AFI_OFS_FAULT);
  wire mclr = wr_ctrl & reg_wdata[AFI_CTRL_MRST];
  wire circ = ctrl_r[AFI_CTRL_CIRC];
  wire slen = ctrl_r[AFI_CTRL_SLEN];

  // ==========================================================
  // Current comparison; the polarization drive has no current sense
  assign over_cur[AFI_AX_AZ] = az_cur > az_ilim_r;
  assign over_cur[AFI_AX_EL] = el_cur > el_ilim_r;
  assign over_cur[AFI_AX_POL] = 1'b0;

  // ==========================================================
  // Recall sequencer for the polarization axis
  wire pol_at_tgt = pol_pos == pol_tgt_r;
  wire pol_up = pol_tgt_r > pol_pos;
  wire seek = rc_state_r == AFI_RC_SEEK;
  // Stop when the needed direction is not enabled, otherwise a block would hang the sequence
  wire seek_stuck = pol_up ? ~en_fwd[AFI_AX_POL] : ~en_rev[AFI_AX_POL];

  always_comb begin
    rc_state_nxt = rc_state_r;
    case (rc_state_r)
      AFI_RC_IDLE: begin
        if (recall_go && !circ && !pol_at_tgt) begin
          rc_state_nxt = AFI_RC_SEEK;
        end
      end
      AFI_RC_SEEK: begin
        if (circ || pol_at_tgt || seek_stuck) begin
          rc_state_nxt = AFI_RC_IDLE;
        end
      end
      default: begin
        rc_state_nxt = AFI_RC_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Per-axis interlock
  wire [2:0] jr = jam | run;

  genvar g;
  generate
    for (g = 0; g < AFI_NAX; g++) begin : g_axis
      afi_axis_mon #(
        .JAM_CYC(JAM_CYC),
        .RUN_CYC(AFI_RUN_CYC)
      ) u_mon (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .cmd(drv_fwd_r[g] | drv_rev_r[g]),
        .moving(moving[g]),
        .over_cur(over_cur[g]),
        .clr(mclr),
        .jam_r(jam[g]),
        .run_r(run[g]),
        .drv_r(dflt[g])
      );
      assign xax[g] = |(jr & ~(3'h1 << g));
      assign blk[g] = jr[g] | dflt[g] | xax[g];
      assign lim_fwd[g] = hw_lim_fwd[g] | (slen & sw_lim_fwd[g]);
      assign lim_rev[g] = hw_lim_rev[g] | (slen & sw_lim_rev[g]);
      assign en_fwd[g] = estop_closed & ~blk[g] & ~lim_fwd[g];
      assign en_rev[g] = estop_closed & ~blk[g] & ~lim_rev[g];
      assign lim_stat[g*AFI_L_STRIDE+AFI_L_HWF] = hw_lim_fwd[g];
      assign lim_stat[g*AFI_L_STRIDE+AFI_L_HWR] = hw_lim_rev[g];
      assign lim_stat[g*AFI_L_STRIDE+AFI_L_SWF] = sw_lim_fwd[g];
      assign lim_stat[g*AFI_L_STRIDE+AFI_L_SWR] = sw_lim_rev[g];
    end
  endgenerate

  // Automatic polarization motion joins the manual request while seeking
  assign req_fwd = cmd_fwd | {seek & ~circ & pol_up, 2'b00};
  assign req_rev = cmd_rev | {seek & ~circ & ~pol_up & ~pol_at_tgt, 2'b00};
  // Opposing requests on one axis drive neither way
  assign drv_fwd_nxt = req_fwd & ~req_rev & en_fwd;
  assign drv_rev_nxt = req_rev & ~req_fwd & en_rev;

  // ==========================================================
  // Status and interrupts
  assign fault_vec = {estop_alarm_r, xax, dflt, run, jam};
  // A new fault in the read cycle survives the read-clear
  assign irq_stat_nxt = (rd_irq ? 13'h0000 : irq_stat_r) | (fault_vec & ~fault_prev_r);

  assign rd_val = (reg_addr == AFI_OFS_CTRL) ? {29'h00000000, ctrl_r} :
                  (reg_addr == AFI_OFS_AZ_ILIM) ? {20'h00000, az_ilim_r} :
                  (reg_addr == AFI_OFS_EL_ILIM) ? {20'h00000, el_ilim_r} :
                  (reg_addr == AFI_OFS_POL_TGT) ? {16'h0000, pol_tgt_r} :
                  (reg_addr == AFI_OFS_LIM_STAT) ? {20'h00000, lim_stat} :
                  (reg_addr == AFI_OFS_FAULT) ? {19'h00000, fault_vec} :
                  (reg_addr == AFI_OFS_IRQ_STAT) ? {19'h00000, irq_stat_r} :
                  (reg_addr == AFI_OFS_IRQ_MASK) ? {19'h00000, irq_mask_r} :
                  32'h00000000;

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= AFI_CTRL_RST;
      az_ilim_r <= AFI_ILIM_RST;
      el_ilim_r <= AFI_ILIM_RST;
      pol_tgt_r <= AFI_POLT_RST;
      irq_mask_r <= AFI_MASK_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_r <= {reg_wdata[AFI_CTRL_SLEN], reg_wdata[AFI_CTRL_CIRC], 1'b0};
      end
      if (wr_az_ilim) begin
        az_ilim_r <= reg_wdata[11:0];
      end
      if (wr_el_ilim) begin
        el_ilim_r <= reg_wdata[11:0];
      end
      if (wr_pol_tgt) begin
        pol_tgt_r <= reg_wdata[15:0];
      end
      if (wr_mask) begin
        irq_mask_r <= reg_wdata[12:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h00000000;
      irq_stat_r <= 13'h0000;
      fault_prev_r <= 13'h0000;
      irq_r <= 1'b0;
    end else if (ce) begin
      rdata_r <= reg_rd ? rd_val : 32'h00000000;
      irq_stat_r <= irq_stat_nxt;
      fault_prev_r <= fault_vec;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drv_fwd_r <= 3'h0;
      drv_rev_r <= 3'h0;
      estop_alarm_r <= 1'b0;
      rc_state_r <= AFI_RC_IDLE;
    end else if (ce) begin
      drv_fwd_r <= drv_fwd_nxt;
      drv_rev_r <= drv_rev_nxt;
      estop_alarm_r <= ~estop_closed;
      rc_state_r <= rc_state_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign drv_fwd = drv_fwd_r;
  assign drv_rev = drv_rev_r;
  assign estop_alarm = estop_alarm_r;
  assign recall_busy = seek;
  assign irq = irq_r;

  // ==========================================================
  // Checks
  az_limit_fwd_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && hw_lim_fwd[AFI_AX_AZ]) |=> !drv_fwd_r[AFI_AX_AZ])
    else $error("azimuth driven into its limit");
  az_limit_back_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && hw_lim_fwd[AFI_AX_AZ] && cmd_rev[AFI_AX_AZ] && !cmd_fwd[AFI_AX_AZ] && estop_closed
     && !blk[AFI_AX_AZ] && !lim_rev[AFI_AX_AZ]) |=> drv_rev_r[AFI_AX_AZ])
    else $error("azimuth cannot leave its limit");
  el_limit_dir_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && hw_lim_rev[AFI_AX_EL] && cmd_fwd[AFI_AX_EL] && !cmd_rev[AFI_AX_EL] && estop_closed
     && !blk[AFI_AX_EL] && !lim_fwd[AFI_AX_EL]) |=> (drv_fwd_r[AFI_AX_EL] && !drv_rev_r[AFI_AX_EL]))
    else $error("elevation limit handling wrong");
  all_axis_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && (|jr)) |=> (drv_fwd_r == 3'h0 && drv_rev_r == 3'h0))
    else $error("motion while jam or runaway latched");
  cross_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rd_fault && jam[AFI_AX_AZ]) |=> (reg_rdata[AFI_F_XAX+1] && reg_rdata[AFI_F_XAX+2]))
    else $error("cross-axis flag missing");
  estop_alarm_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !estop_closed) |=> (estop_alarm_r && drv_fwd_r == 3'h0 && drv_rev_r == 3'h0))
    else $error("emergency stop not honoured");
  estop_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && estop_closed) |=> !estop_alarm_r)
    else $error("emergency stop alarm stuck");
  recall_start_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !seek && recall_go && !circ && !pol_at_tgt) |=> recall_busy)
    else $error("recall did not start polarization seek");
  circ_suppress_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && circ) |=> !recall_busy)
    else $error("automatic polarization under circular feed");
  hw_sw_split_a: assert property (@(posedge clk) disable iff (!rstn)
    (ce && reg_rd && reg_addr == AFI_OFS_LIM_STAT) |=>
    (reg_rdata[AFI_L_HWF] == $past(hw_lim_fwd[0]) && reg_rdata[AFI_L_SWF] == $past(sw_lim_fwd[0])))
    else $error("limit status readback wrong");

endmodule

//--- sim/afi_drive_model.sv
// Behavioural motor drives and position feedback facing the interlock
`timescale 1ns/1ns
module afi_drive_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Drive enables from the interlock
  input wire logic [2:0] drv_fwd,
  input wire logic [2:0] drv_rev,
  // Fault injection: stalled motor, motor turning on its own
  input wire logic [2:0] stuck,
  input wire logic [2:0] coast,
  // Feedback
  output logic [2:0] moving,
  output logic [15:0] pol_pos
);
  logic [2:0] run_r;
  logic [2:0] step_r;

  // ====
  // Motion
  // Feedback lags the drive by one cycle, as a motor spinning up would
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= 3'h0;
      step_r <= 3'h0;
      pol_pos <= 16'h0100;
    end else begin
      run_r <= drv_fwd | drv_rev;
      if (drv_fwd[2] | drv_rev[2]) begin
        step_r <= step_r + 3'h1;
      end
      // Slow motor: one count per eight driven cycles, so a late stop cannot overshoot
      if (step_r == 3'h7 && drv_fwd[2]) begin
        pol_pos <= pol_pos + 16'h1;
      end else if (step_r == 3'h7 && drv_rev[2]) begin
        pol_pos <= pol_pos - 16'h1;
      end
    end
  end

  assign moving = (run_r & ~stuck) | coast;
endmodule

//--- sim/afi_interlock_test.sv
// Self-checking bench for the axis interlock
`timescale 1ns/1ns
module afi_interlock_test;
  import afi_pkg::*;

  // One nibble per field: cmd fwd, cmd rev, hw fwd, hw rev, sw fwd, sw rev, stop closed, exp fwd, exp rev
  typedef struct packed {
    logic [3:0] cf, cr, hf, hr, sf, sr, es, ef, er;
  } afi_row_t;

  localparam afi_row_t IDLE = 36'h000000100;
  localparam afi_row_t ROWS [13] = '{
    36'h700000170, 36'h070000107, 36'h701000160, 36'h070100106,
    36'h702000150, 36'h700200170, 36'h070200105, 36'h700040130,
    36'h071001106, 36'h710000160, 36'h700000000, 36'h704000130, 36'h071000107
  };

  logic clk, rstn, ce, reg_wr, reg_rd, recall_go, estop_closed, estop_alarm, recall_busy, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] cmd_fwd, cmd_rev, hw_lim_fwd, hw_lim_rev, sw_lim_fwd, sw_lim_rev;
  logic [2:0] moving, drv_fwd, drv_rev, stuck, coast;
  logic [11:0] az_cur, el_cur;
  logic [15:0] pol_pos, tgt;
  int n_errors = 0;
  int cmp_count = 0;

  afi_interlock #(.JAM_CYC(20)) uut (
    .clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmd_fwd, .cmd_rev, .recall_go, .hw_lim_fwd, .hw_lim_rev, .sw_lim_fwd, .sw_lim_rev,
    .moving, .az_cur, .el_cur, .pol_pos, .estop_closed, .drv_fwd, .drv_rev,
    .estop_alarm, .recall_busy, .irq
  );
  afi_drive_model drives (.clk, .rstn, .drv_fwd, .drv_rev, .stuck, .coast, .moving, .pol_pos);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ====
  // Helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask

  task automatic apply(input afi_row_t r);
    @(posedge clk);
    cmd_fwd <= r.cf[2:0];
    cmd_rev <= r.cr[2:0];
    hw_lim_fwd <= r.hf[2:0];
    hw_lim_rev <= r.hr[2:0];
    sw_lim_fwd <= r.sf[2:0];
    sw_lim_rev <= r.sr[2:0];
    estop_closed <= r.es[0];
  endtask

  // Pulse the recall request, then wait a bounded time for the seek to finish
  task automatic recall(input logic exp_busy);
    @(posedge clk);
    recall_go <= 1'b1;
    @(posedge clk);
    recall_go <= 1'b0;
    tick(1);
    chk("recall busy", {31'h0, exp_busy}, {31'h0, recall_busy});
    for (int k = 0; k < 300 && recall_busy === 1'b1; k++) tick(1);
    tick(3);
  endtask

  function automatic logic [31:0] lim_exp(input afi_row_t r);
    lim_exp = 32'h0;
    for (int a = 0; a < AFI_NAX; a++) lim_exp[AFI_L_STRIDE*a +: 4] = {r.sr[a], r.sf[a], r.hr[a], r.hf[a]};
  endfunction

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ====
  // Main sequence
  initial begin
    {rstn, reg_wr, reg_rd, recall_go, reg_addr, reg_wdata, stuck, coast, az_cur, el_cur} = '0;
    {cmd_fwd, cmd_rev, hw_lim_fwd, hw_lim_rev, sw_lim_fwd, sw_lim_rev} = '0;
    estop_closed = 1'b1;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdchk(AFI_OFS_CTRL, 32'h4, "ctrl");
    rdchk(AFI_OFS_AZ_ILIM, 32'hFFF, "az ilim");
    rdchk(AFI_OFS_EL_ILIM, 32'hFFF, "el ilim");
    rdchk(AFI_OFS_POL_TGT, 32'h0, "pol tgt");
    rdchk(AFI_OFS_IRQ_MASK, 32'h0, "mask");
    rdchk(8'h20, 32'h0, "unmapped");
    foreach (ROWS[i]) begin
      apply(ROWS[i]);
      tick(3);
      chk("drv_fwd", {28'h0, ROWS[i].ef}, {29'h0, drv_fwd});
      chk("drv_rev", {28'h0, ROWS[i].er}, {29'h0, drv_rev});
      chk("estop_alarm", {31'h0, ~ROWS[i].es[0]}, {31'h0, estop_alarm});
      rdchk(AFI_OFS_LIM_STAT, lim_exp(ROWS[i]), "lim stat");
    end
    // Software limits are still reported while they no longer stop motion
    wr(AFI_OFS_CTRL, 32'h0);
    apply(36'h700040170);
    tick(3);
    chk("sw lim off", 32'h7, {29'h0, drv_fwd});
    rdchk(AFI_OFS_LIM_STAT, 32'h400, "sw lim seen");
    wr(AFI_OFS_CTRL, 32'h4);
    // Interrupt: raise, mask, unmask, clear by read
    apply(IDLE);
    rdchk(AFI_OFS_IRQ_STAT, 32'h1000, "stat after rows");
    wr(AFI_OFS_IRQ_MASK, 32'h1000);
    tick(3);
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge clk);
    estop_closed <= 1'b0;
    tick(3);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(AFI_OFS_IRQ_MASK, 32'h0);
    tick(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(AFI_OFS_IRQ_MASK, 32'h1000);
    tick(3);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rdchk(AFI_OFS_IRQ_STAT, 32'h1000, "irq stat");
    tick(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdchk(AFI_OFS_FAULT, 32'h1000, "stop fault");
    apply(IDLE);
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'h0, "stop restored");
    // Over-current: at the limit nothing, one above latches
    wr(AFI_OFS_AZ_ILIM, 32'h100);
    wr(AFI_OFS_EL_ILIM, 32'h80);
    apply(36'h700000100);
    @(posedge clk);
    az_cur <= 12'h100;
    el_cur <= 12'h080;
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'h0, "at limit");
    @(posedge clk);
    az_cur <= 12'h101;
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'h40, "az drive");
    chk("drv az blocked", 32'h6, {29'h0, drv_fwd});
    @(posedge clk);
    az_cur <= 12'h0;
    el_cur <= 12'h081;
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'hC0, "both drive");
    @(posedge clk);
    el_cur <= 12'h0;
    wr(AFI_OFS_CTRL, 32'h5);
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'h0, "drive cleared");
    chk("drv resumed", 32'h7, {29'h0, drv_fwd});
    // Stalled azimuth motor blocks every axis
    apply(IDLE);
    @(posedge clk);
    stuck <= 3'h1;
    cmd_fwd <= 3'h1;
    tick(30);
    rdchk(AFI_OFS_FAULT, 32'hC01, "jam");
    @(posedge clk);
    cmd_fwd <= 3'h7;
    tick(3);
    chk("all blocked", 32'h0, {29'h0, drv_fwd});
    @(posedge clk);
    stuck <= 3'h0;
    wr(AFI_OFS_CTRL, 32'h5);
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'h0, "jam cleared");
    chk("all resumed", 32'h7, {29'h0, drv_fwd});
    // Elevation turning with no drive
    apply(IDLE);
    @(posedge clk);
    coast <= 3'h2;
    tick(110);
    rdchk(AFI_OFS_FAULT, 32'hA10, "runaway");
    @(posedge clk);
    coast <= 3'h0;
    wr(AFI_OFS_CTRL, 32'h5);
    tick(3);
    rdchk(AFI_OFS_FAULT, 32'h0, "run cleared");
    // Recall seeks polarization; circular feed suppresses it
    tgt = pol_pos + 16'h8;
    wr(AFI_OFS_POL_TGT, {16'h0, tgt});
    recall(1'b1);
    chk("pol fwd seek", {16'h0, tgt}, {16'h0, pol_pos});
    wr(AFI_OFS_CTRL, 32'h6);
    tgt = pol_pos - 16'h4;
    wr(AFI_OFS_POL_TGT, {16'h0, tgt});
    recall(1'b0);
    chk("circ no seek", {16'h0, tgt + 16'h4}, {16'h0, pol_pos});
    chk("circ no drive", 32'h0, {29'h0, drv_rev});
    wr(AFI_OFS_CTRL, 32'h4);
    recall(1'b1);
    chk("pol rev seek", {16'h0, tgt}, {16'h0, pol_pos});
    // Clock enable low freezes every interlock flop, the stop alarm included
    @(posedge clk);
    ce <= 1'b0;
    estop_closed <= 1'b0;
    tick(3);
    chk("alarm frozen", 32'h0, {31'h0, estop_alarm});
    @(posedge clk);
    ce <= 1'b1;
    tick(2);
    chk("alarm thawed", 32'h1, {31'h0, estop_alarm});
    summarize();
  end
endmodule
